// file: shared/bec_params.svh
`ifndef BEC_PARAMS_SVH
`define BEC_PARAMS_SVH
// register indexes on the plain port
`define BEC_IDX_CORE_LO     3'h0
`define BEC_IDX_CORE_HI     3'h1
`define BEC_IDX_CACHE_LO    3'h2
`define BEC_IDX_CACHE_HI    3'h3
`define BEC_IDX_CTRL        3'h4
`define BEC_IDX_TMO_CNT     3'h5
// status field positions
`define BEC_BIT_TIMEOUT     38
`define BEC_BIT_HARD_ERR    42
`define BEC_BIT_INT_FAULT   43
`define BEC_VALID_LSB       57
`define BEC_MS_REQ_PAR      16
`define BEC_MS_HARD_FAIL    20
`define BEC_MS_RSP_PAR      21
`define BEC_MS_DATA_PAR     22
`define BEC_INFO_LSB        32
`define BEC_INFO_MSB        56
// error type codes
`define BEC_CODE_INTERNAL   16'h0400
`define BEC_CODE_BUS        16'h0E0F
// writable bits of the status words (rest reads zero)
`define BEC_CORE_MASK       64'h0000_0C40_0000_0000
`define BEC_CACHE_MASK      64'h01FF_FFFF_0071_FFFF
// timing
`define BEC_PRESCALE_DIV    128
`define BEC_PRESCALE_W      8
`define BEC_TMO_W           23
// control reset: divide by 2
`define BEC_CTRL_RESET      2'h0
`endif

// file: shared/bec_pkg.sv
package bec_pkg;
   typedef enum logic [1:0] {
      BEC_DIV2 = 2'b00,
      BEC_DIV3 = 2'b01,
      BEC_DIV4 = 2'b10
   } bec_ratio_t;

   typedef struct packed {
      logic retire;
      logic core_exc;
      logic bus_reinit;
   } bec_core_ev_t;

   typedef struct packed {
      logic hard_fail;
      logic int_fault;
      logic req_par;
      logic rsp_par;
      logic data_par;
      logic corr_event;
   } bec_bus_ev_t;
endpackage

// file: logic/bec_retire_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "bec_params.svh"
module bec_retire_timer (
   input  wire logic              clk_sys,   // core clock
   input  wire logic              rst,       // sync reset
   input  wire logic              ce,        // clock enable
   input  wire bec_pkg::bec_ratio_t ratio,   // bus clock ratio
   input  wire logic              clr,       // clear counter
   output logic                   timeout,   // one-cycle carry-out pulse
   output logic [22:0]            count      // counter value
);
   import bec_pkg::*;
   logic [1:0] bus_div_q;
   logic       bus_tick;
   logic [7:0] pre_q;
   logic [1:0] ratio_max;

   always_comb begin
      unique case (ratio)
         BEC_DIV2: ratio_max = 2'h1;
         BEC_DIV3: ratio_max = 2'h2;
         BEC_DIV4: ratio_max = 2'h3;
         default:  ratio_max = 2'h1;
      endcase
   end

   // bus clock modelled as an enable at 1:2, 1:3 or 1:4 of the core clock
   assign bus_tick = (bus_div_q == ratio_max);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         bus_div_q <= 2'h0;
      end else if (ce) begin
         bus_div_q <= bus_tick ? 2'h0 : bus_div_q + 2'h1;
      end
   end

   // 8-bit prescaler wraps at 128 bus clocks
   always_ff @(posedge clk_sys) begin
      if (rst || (ce && clr)) begin
         pre_q <= 8'h00;
      end else if (ce && bus_tick) begin
         pre_q <= (pre_q == 8'(`BEC_PRESCALE_DIV - 1)) ? 8'h00 : pre_q + 8'h01;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         count   <= 23'h000000;
         timeout <= 1'b0;
      end else if (ce) begin
         timeout <= 1'b0;
         if (clr) begin
            count <= 23'h000000;
         end else if (bus_tick && pre_q == 8'(`BEC_PRESCALE_DIV - 1)) begin
            {timeout, count} <= {1'b0, count} + 24'h000001;
         end
      end
   end
endmodule
`default_nettype wire

// file: logic/bec_error_logger.sv
// Overview of operation
// - prescaler divides bus clock by 128
// - bus clock is 1:2, 1:3 or 1:4
// - timeout bit sticky until cleared
// - bit 42 logs hard error response
// - bit 43 logs internal fault pin
// - bits 57-63 reserved for validity
// - cache bank status logs bus errors
// - internal error code 0x0400 in 15:0
// - bus error code 0x0E0F
// - reserved bus code variants never produced
// - model-specific detail in bits 31:16
// - bits 56:32 hold correctable event count
// - bit 16 request parity error
// - bit 20 local hard failure response
// - bit 21 response parity error
// - bit 22 inbound data parity error
// - 23-bit carry-out sets bit 38
// - counter clears on retire, exception, reset, reinit
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "bec_params.svh"
module bec_error_logger (
   input  wire logic                 clk_sys,    // core clock
   input  wire logic                 rst,        // sync reset
   input  wire logic                 ce,         // clock enable
   input  wire bec_pkg::bec_core_ev_t core_ev,   // core events
   input  wire bec_pkg::bec_bus_ev_t  bus_ev,    // bus events
   input  wire logic [2:0]           addr,       // register index
   input  wire logic [31:0]          wdata,      // write data
   input  wire logic                 wr,         // write strobe
   input  wire logic                 rd,         // read strobe
   output logic [31:0]               rdata,      // read data, cycle after rd
   output logic                      timeout_q,  // retirement time-out logged
   output logic                      error_q     // any error logged
);
   import bec_pkg::*;

   logic [63:0] core_q;
   logic [63:0] cache_q;
   bec_ratio_t  ratio_q;
   logic        tmo_pulse;
   logic [22:0] tmo_count;
   logic        tmo_clr;
   logic        any_bus;
   logic        any_int;
   logic [63:0] core_wr;
   logic [63:0] cache_wr;
   logic [15:0] ms_new;

   assign tmo_clr = core_ev.retire | core_ev.core_exc | core_ev.bus_reinit;

   bec_retire_timer u_timer (
      .clk_sys (clk_sys),
      .rst     (rst),
      .ce      (ce),
      .ratio   (ratio_q),
      .clr     (tmo_clr),
      .timeout (tmo_pulse),
      .count   (tmo_count)
   );

   assign any_bus = bus_ev.req_par | bus_ev.rsp_par | bus_ev.data_par | bus_ev.hard_fail;
   assign any_int = bus_ev.int_fault;

   always_comb begin
      ms_new = 16'h0000;
      ms_new[`BEC_MS_REQ_PAR - 16]   = bus_ev.req_par;
      ms_new[`BEC_MS_HARD_FAIL - 16] = bus_ev.hard_fail;
      ms_new[`BEC_MS_RSP_PAR - 16]   = bus_ev.rsp_par;
      ms_new[`BEC_MS_DATA_PAR - 16]  = bus_ev.data_par;
   end

   // software writes one 32-bit half; only writable bits take effect
   always_comb begin
      core_wr  = core_q;
      cache_wr = cache_q;
      if (wr) begin
         unique case (addr)
            `BEC_IDX_CORE_LO:  core_wr[31:0]   = wdata;
            `BEC_IDX_CORE_HI:  core_wr[63:32]  = wdata;
            `BEC_IDX_CACHE_LO: cache_wr[31:0]  = wdata;
            `BEC_IDX_CACHE_HI: cache_wr[63:32] = wdata;
            default: ;
         endcase
      end
      core_wr  = core_wr & `BEC_CORE_MASK;
      cache_wr = cache_wr & `BEC_CACHE_MASK;
   end

   // core-facing status: sticky bits, an event wins over a same-cycle clear
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         core_q <= 64'h0000_0000_0000_0000;
      end else if (ce) begin
         core_q <= core_wr;
         if (tmo_pulse || core_q[`BEC_BIT_TIMEOUT]) begin
            core_q[`BEC_BIT_TIMEOUT] <= 1'b1;
         end
         if (bus_ev.hard_fail || core_q[`BEC_BIT_HARD_ERR]) begin
            core_q[`BEC_BIT_HARD_ERR] <= 1'b1;
         end
         if (bus_ev.int_fault || core_q[`BEC_BIT_INT_FAULT]) begin
            core_q[`BEC_BIT_INT_FAULT] <= 1'b1;
         end
         if (wr && (addr == `BEC_IDX_CORE_HI)) begin
            core_q[`BEC_BIT_TIMEOUT]   <= tmo_pulse | wdata[`BEC_BIT_TIMEOUT - 32];
            core_q[`BEC_BIT_HARD_ERR]  <= bus_ev.hard_fail | wdata[`BEC_BIT_HARD_ERR - 32];
            core_q[`BEC_BIT_INT_FAULT] <= bus_ev.int_fault | wdata[`BEC_BIT_INT_FAULT - 32];
         end
      end
   end

   // cache/bus bank: first error owns the code in 15:0 until cleared; while that code is 0x0E0F, later bus errors OR their detail bits into 31:16
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cache_q <= 64'h0000_0000_0000_0000;
      end else if (ce) begin
         cache_q <= cache_wr;
         if (cache_q[15:0] == 16'h0000 || (wr && addr == `BEC_IDX_CACHE_LO)) begin
            if (any_bus) begin
               cache_q[15:0]  <= `BEC_CODE_BUS;
               cache_q[31:16] <= ms_new;
            end else if (any_int) begin
               cache_q[15:0]  <= `BEC_CODE_INTERNAL;
               cache_q[31:16] <= 16'h0000;
            end
         end else if (cache_q[15:0] == `BEC_CODE_BUS && any_bus) begin
            cache_q[31:16] <= cache_q[31:16] | ms_new;
         end
         if (bus_ev.corr_event) begin
            // count saturates rather than wrapping to zero
            if (cache_wr[56:32] != 25'h1FFFFFF) begin
               cache_q[56:32] <= cache_wr[56:32] + 25'h0000001;
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ratio_q <= BEC_DIV2;
      end else if (ce && wr && addr == `BEC_IDX_CTRL) begin
         // an illegal code falls back to the slowest legal one
         ratio_q <= (wdata[1:0] == 2'h3) ? BEC_DIV4 : bec_ratio_t'(wdata[1:0]);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdata <= 32'h0000_0000;
      end else if (ce) begin
         rdata <= 32'h0000_0000;
         if (rd) begin
            unique case (addr)
               `BEC_IDX_CORE_LO:  rdata <= core_q[31:0];
               `BEC_IDX_CORE_HI:  rdata <= core_q[63:32];
               `BEC_IDX_CACHE_LO: rdata <= cache_q[31:0];
               `BEC_IDX_CACHE_HI: rdata <= cache_q[63:32];
               `BEC_IDX_CTRL:     rdata <= {30'h0, ratio_q};
               `BEC_IDX_TMO_CNT:  rdata <= {9'h000, tmo_count};
               default:           rdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         timeout_q <= 1'b0;
         error_q   <= 1'b0;
      end else if (ce) begin
         timeout_q <= core_q[`BEC_BIT_TIMEOUT];
         error_q   <= (|core_q) | (|cache_q[31:0]);
      end
   end
endmodule
`default_nettype wire

// file: testbench/bec_error_logger_chk.sv
`timescale 1ns/1ps
`default_nettype none
module bec_error_logger_chk (
   input wire logic                  clk_sys,   // core clock
   input wire logic                  rst,       // sync reset
   input wire logic                  ce,        // clock enable
   input wire bec_pkg::bec_core_ev_t core_ev,   // core events
   input wire bec_pkg::bec_bus_ev_t  bus_ev,    // bus events
   input wire logic [2:0]            addr,      // register index
   input wire logic                  wr,        // write strobe
   input wire logic                  rd,        // read strobe
   input wire logic [31:0]           rdata,     // read data
   input wire logic                  timeout_q, // time-out logged
   input wire logic                  error_q    // error logged
);
   import bec_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   unmapped_zero_a: assert property (ce && rd && addr[2:1] == 2'b11 |=> rdata == '0)
      else $error("unmapped read not zero");
   core_rsvd_a: assert property (ce && rd && addr == 3'h1 |=> (rdata & ~32'h0000_0C40) == '0)
      else $error("core status reserved bit set");
   valid_rsvd_a: assert property (ce && rd && addr == 3'h3 |=> rdata[31:25] == '0)
      else $error("validity bits not zero");
   ms_rsvd_a: assert property (ce && rd && addr == 3'h2 |=> (rdata & 32'hFF8E_0000) == '0)
      else $error("reserved detail bit set");
   code_set_a: assert property (ce && rd && addr == 3'h2 |=> rdata[15:0] inside {16'h0000, 16'h0400, 16'h0E0F})
      else $error("unused error code produced");
   hard_err_a: assert property (ce && bus_ev.hard_fail |-> ##[1:3] error_q)
      else $error("hard failure not logged");
   err_hold_a: assert property ($fell(error_q) |-> $past(wr) || $past(wr, 2))
      else $error("error log dropped without write");
   tmo_hold_a: assert property ($fell(timeout_q) |-> $past(wr) || $past(wr, 2))
      else $error("time-out log dropped without write");
   cnt_clear_a: assert property (ce && core_ev.retire ##[1:2] (ce && rd && addr == 3'h5) |=> rdata == '0)
      else $error("time-out count not cleared");
   cnt_width_a: assert property (ce && rd && addr == 3'h5 |=> rdata[31:23] == '0)
      else $error("time-out count wider than 23 bits");
endmodule
bind bec_error_logger bec_error_logger_chk u_chk (.clk_sys(clk_sys), .rst(rst), .ce(ce), .core_ev(core_ev),
   .bus_ev(bus_ev), .addr(addr), .wr(wr), .rd(rd), .rdata(rdata), .timeout_q(timeout_q), .error_q(error_q));
`default_nettype wire

// file: testbench/bec_bus_agent.sv
`timescale 1ns/1ps
`default_nettype none
module bec_bus_agent (
   input  wire logic                 clk_sys, // core clock
   output var bec_pkg::bec_core_ev_t core_ev, // core events
   output var bec_pkg::bec_bus_ev_t  bus_ev   // bus events
);
   import bec_pkg::*;
   initial begin
      core_ev = '0;
      bus_ev = '0;
   end
   // events are one-cycle pulses; a held corr_event level would count once per cycle
   task automatic pulse(input logic [2:0] c, input logic [5:0] b);
      @(posedge clk_sys);
      core_ev <= c;
      bus_ev <= b;
      @(posedge clk_sys);
      core_ev <= '0;
      bus_ev <= '0;
   endtask
endmodule
`default_nettype wire

// file: testbench/bec_error_logger_bench.sv
`timescale 1ns/1ps
`default_nettype none
module bec_error_logger_bench;
   import bec_pkg::*;
   logic         clk_sys = 1'b0;
   logic         rst = 1'b1;
   logic [2:0]   addr = 3'h0;
   logic [31:0]  wdata = 32'h0;
   logic         wr = 1'b0;
   logic         rd = 1'b0;
   logic         ce = 1'b1;
   logic [31:0]  rdata;
   logic         timeout_q;
   logic         error_q;
   bec_core_ev_t core_ev;
   bec_bus_ev_t  bus_ev;
   int           err_count = 0;
   int           comparisons = 0;
   always #4 clk_sys = ~clk_sys;
   bec_bus_agent agent (.clk_sys(clk_sys), .core_ev(core_ev), .bus_ev(bus_ev));
   bec_error_logger uut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .core_ev(core_ev), .bus_ev(bus_ev),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .timeout_q(timeout_q), .error_q(error_q));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr_reg(input logic [2:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask
   // read data stand for one cycle only, so sample at the falling edge inside it
   task automatic rd_chk(input logic [2:0] a, input logic [31:0] exp);
      @(posedge clk_sys);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk_sys);
      rd <= 1'b0;
      @(negedge clk_sys);
      chk($sformatf("reg %0d", a), exp, rdata);
   endtask
   task automatic clear_all();
      for (int i = 0; i < 4; i++) wr_reg(3'(i), 32'h0);
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++) rd_chk(3'(i), 32'h0);
      agent.pulse(3'h0, 6'h20);
      rd_chk(3'h1, 32'h0000_0400);
      rd_chk(3'h2, 32'h0010_0E0F);
      chk("error_q", 32'h1, {31'h0, error_q});
      agent.pulse(3'h0, 6'h30);
      rd_chk(3'h1, 32'h0000_0C00);
      wr_reg(3'h1, 32'hFFFF_FFFF);
      rd_chk(3'h1, 32'h0000_0C40);
      chk("timeout_q", 32'h1, {31'h0, timeout_q});
      clear_all();
      // a frozen block must not log an event that arrives while ce is low
      @(posedge clk_sys);
      ce <= 1'b0;
      agent.pulse(3'h0, 6'h20);
      @(posedge clk_sys);
      ce <= 1'b1;
      rd_chk(3'h1, 32'h0000_0000);
      rd_chk(3'h2, 32'h0000_0000);
      agent.pulse(3'h0, 6'h10);
      rd_chk(3'h2, 32'h0000_0400);
      clear_all();
      agent.pulse(3'h0, 6'h08);
      rd_chk(3'h2, 32'h0001_0E0F);
      agent.pulse(3'h0, 6'h04);
      rd_chk(3'h2, 32'h0021_0E0F);
      agent.pulse(3'h0, 6'h02);
      rd_chk(3'h2, 32'h0061_0E0F);
      repeat (3) agent.pulse(3'h0, 6'h01);
      rd_chk(3'h3, 32'h0000_0003);
      wr_reg(3'h3, 32'hFFFF_FFFF);
      rd_chk(3'h3, 32'h01FF_FFFF);
      // each ratio is cleared by a different core event; the slack of 10 stays well below one step
      for (int r = 0; r < 3; r++) begin
         wr_reg(3'h4, 32'(r));
         agent.pulse(3'h4 >> r, 6'h00);
         rd_chk(3'h5, 32'h0);
         repeat (128 * (r + 2) * 3 + 10) @(posedge clk_sys);
         rd_chk(3'h5, 32'h3);
      end
      results();
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      err_count++;
      results();
   end
endmodule
`default_nettype wire
